// [clock_divider.sv]
// programmable divider used for postscaler and clock output
`timescale 1ns/100ps
module clock_divider #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] ratio,
    input wire logic enable,
    output logic tick
);
    logic [WIDTH-1:0] count_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_q <= '0;
            tick <= 1'b0;
        end else if (!enable) begin
            count_q <= '0;
            tick <= 1'b0;
        end else if (count_q >= ratio) begin
            count_q <= '0;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : clock_divider

// [osc_select.sv]
// oscillator source selection, trim and clock control
`timescale 1ns/100ps
`include "osc_select_cfg.svh"
module osc_select #(
    parameter logic [2:0] MUL_RESET = 3'h0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] switch_monitor_config,
    input wire logic [2:0] initial_source_config,
    input wire logic [1:0] primary_submode_config,
    input wire logic sourceReady,
    input wire logic activeClockPulse,
    output logic [2:0] sourceSelect,
    output logic [1:0] primarySubmode,
    output logic [5:0] rc_trim_code,
    output logic [2:0] usbMultiplier,
    output logic cpuClockTick,
    output logic clockOut,
    output logic clockFail
);
    import osc_select_pkg::*;
    // ----------------------------------------
    // synchronised pins
    // ----------------------------------------
    logic [2:0] readySync_q;
    logic [2:0] pulseSync_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readySync_q <= 3'h0;
            pulseSync_q <= 3'h0;
        end else begin
            readySync_q <= {readySync_q[1:0], sourceReady};
            pulseSync_q <= {pulseSync_q[1:0], activeClockPulse};
        end
    end
    logic readyNow;
    logic pulseSeen;
    assign readyNow = readySync_q[2] & readySync_q[1];
    assign pulseSeen = (pulseSync_q[2] != pulseSync_q[1]);
    // ----------------------------------------
    // configuration latched after reset
    // ----------------------------------------
    logic cfgDone_q;
    logic switchEnable_q;
    logic monitorEnable_q;
    logic [2:0] initSrc_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfgDone_q <= 1'b0;
            switchEnable_q <= 1'b0;
            monitorEnable_q <= 1'b0;
            initSrc_q <= 3'h0;
            primarySubmode <= 2'h3;
        end else if (!cfgDone_q) begin
            cfgDone_q <= 1'b1;
            switchEnable_q <= (switch_monitor_config == 2'h0);
            monitorEnable_q <= !switch_monitor_config[1];
            initSrc_q <= initial_source_config;
            primarySubmode <= primary_submode_config;
        end
    end
    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic access;
    logic wrCtl;
    logic wrTrim;
    logic wrKey;
    logic wrDiv;
    assign access = wb_cyc_i & wb_stb_i & !wb_ack_o;
    assign wrCtl = access & wb_we_i & (wb_adr_i == `OFS_CONTROL);
    assign wrTrim = access & wb_we_i & (wb_adr_i == `OFS_TRIM) & wb_sel_i[0];
    assign wrKey = access & wb_we_i & (wb_adr_i == `OFS_KEY) & wb_sel_i[0];
    assign wrDiv = access & wb_we_i & (wb_adr_i == `OFS_DIVIDE);
    // ----------------------------------------
    // unlock sequence
    // ----------------------------------------
    logic [1:0] keyStage_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            keyStage_q <= 2'h0;
        end else if (wrKey) begin
            if (wb_dat_i[7:0] == `KEY_FIRST) begin
                keyStage_q <= 2'h1;
            end else if (keyStage_q == 2'h1 && wb_dat_i[7:0] == `KEY_SECOND) begin
                keyStage_q <= 2'h2;
            end else begin
                keyStage_q <= 2'h0;
            end
        end else if (wrCtl && wb_sel_i[1]) begin
            keyStage_q <= 2'h0;
        end
    end
    // ----------------------------------------
    // source switching
    // ----------------------------------------
    switch_state_t state_q;
    logic [2:0] newSrc_q;
    logic request_q;
    logic [3:0] wait_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            newSrc_q <= 3'h0;
        end else if (!cfgDone_q) begin
            newSrc_q <= initial_source_config;
        end else if (wrCtl && wb_sel_i[1] && keyStage_q == 2'h2) begin
            newSrc_q <= wb_dat_i[`POS_NEW +: `WID_SRC];
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= SW_IDLE;
            request_q <= 1'b0;
            wait_q <= 4'h0;
            sourceSelect <= 3'h0;
        end else if (!cfgDone_q) begin
            sourceSelect <= initial_source_config;
        end else if (!switchEnable_q) begin
            request_q <= 1'b0;
            state_q <= SW_IDLE;
            sourceSelect <= initSrc_q;
        end else begin
            case (state_q)
                SW_IDLE: begin
                    if (wrCtl && wb_sel_i[0] && wb_dat_i[`POS_REQUEST]) begin
                        request_q <= 1'b1;
                        wait_q <= `SWITCH_DELAY;
                        state_q <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (wait_q != 4'h0) begin
                        wait_q <= wait_q - 4'h1;
                    end else if (readyNow) begin
                        state_q <= SW_ADOPT;
                    end
                end
                SW_ADOPT: begin
                    sourceSelect <= newSrc_q;
                    request_q <= 1'b0;
                    state_q <= SW_IDLE;
                end
                default: begin
                    state_q <= SW_IDLE;
                end
            endcase
        end
    end
    // ----------------------------------------
    // fail-safe monitor
    // ----------------------------------------
    logic [7:0] silent_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            silent_q <= 8'h00;
            clockFail <= 1'b0;
        end else if (!monitorEnable_q || pulseSeen) begin
            silent_q <= 8'h00;
            if (wrCtl && wb_sel_i[0] && !wb_dat_i[`POS_FAIL]) begin
                clockFail <= 1'b0;
            end
        end else if (silent_q == `MONITOR_LIMIT) begin
            clockFail <= 1'b1;
        end else begin
            silent_q <= silent_q + 8'h01;
            if (wrCtl && wb_sel_i[0] && !wb_dat_i[`POS_FAIL]) begin
                clockFail <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // trim and divide registers
    // ----------------------------------------
    logic [15:0] divide_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rc_trim_code <= `RST_TRIM;
        end else if (wrTrim) begin
            rc_trim_code <= wb_dat_i[5:0];
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divide_q <= `RST_DIVIDE;
            usbMultiplier <= MUL_RESET;
        end else if (wrDiv) begin
            if (wb_sel_i[0]) begin
                divide_q[7:0] <= wb_dat_i[7:0];
                usbMultiplier <= wb_dat_i[`POS_MUL +: 3];
            end
            if (wb_sel_i[1]) begin
                divide_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end
    // ----------------------------------------
    // postscaler and clock output
    // ----------------------------------------
    logic outTick;
    clock_divider #(.WIDTH(3)) postDiv (
        .clk_sys(clk_sys),
        .rst(rst),
        .ratio(divide_q[`POS_POST +: 3]),
        .enable(1'b1),
        .tick(cpuClockTick)
    );
    clock_divider #(.WIDTH(7)) outDiv (
        .clk_sys(clk_sys),
        .rst(rst),
        .ratio(divide_q[`POS_OUTDIV +: 7]),
        .enable(divide_q[`POS_OUTEN]),
        .tick(outTick)
    );
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clockOut <= 1'b0;
        end else if (!divide_q[`POS_OUTEN]) begin
            clockOut <= 1'b0;
        end else if (outTick) begin
            clockOut <= !clockOut;
        end
    end
    // ----------------------------------------
    // read data and acknowledge
    // ----------------------------------------
    logic [31:0] readData;
    always_comb begin
        readData = 32'h0000_0000;
        case (wb_adr_i)
            `OFS_CONTROL: begin
                readData[`POS_REQUEST] = request_q;
                readData[`POS_FAIL] = clockFail;
                readData[`POS_LOCK] = (keyStage_q != 2'h2);
                readData[`POS_NEW +: `WID_SRC] = newSrc_q;
                readData[`POS_CUR +: `WID_SRC] = sourceSelect;
            end
            `OFS_TRIM: readData[5:0] = rc_trim_code;
            `OFS_KEY: readData[1:0] = keyStage_q;
            `OFS_DIVIDE: readData[15:0] = {divide_q[15:8], 1'b0, usbMultiplier, divide_q[3:0]};
            default: readData = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= access ? readData : 32'h0000_0000;
        end
    end
endmodule : osc_select

// [osc_select_cfg.svh]
// constants for the oscillator select and trim block
`ifndef OSC_SELECT_CFG_SVH
`define OSC_SELECT_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_TRIM 4'h4
`define OFS_KEY 4'h8
`define OFS_DIVIDE 4'hC
// ----------------------------------------
// fields of control register
// ----------------------------------------
`define POS_REQUEST 0
`define POS_FAIL 3
`define POS_LOCK 7
`define POS_NEW 8
`define POS_CUR 12
`define WID_SRC 3
// ----------------------------------------
// fields of divide register
// ----------------------------------------
`define POS_POST 0
`define POS_MUL 4
`define POS_OUTDIV 8
`define POS_OUTEN 15
// ----------------------------------------
// values
// ----------------------------------------
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'h57
`define RST_TRIM 6'h00
`define RST_DIVIDE 16'h0000
`define TRIM_MAX 6'h1F
`define TRIM_MIN 6'h20
`define MONITOR_LIMIT 8'hFF
`define SWITCH_DELAY 4'h8
`define USB_FREQ_MHZ 48
`define NUM_CLOCK_MODES 11
`endif

// [osc_select_monitor.sv]
// port assertions for the oscillator select block
`timescale 1ns/100ps
module osc_select_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] switch_monitor_config,
    input wire logic sourceReady,
    input wire logic [2:0] sourceSelect,
    input wire logic [1:0] primarySubmode,
    input wire logic [5:0] rc_trim_code,
    input wire logic clockFail
);
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // --------
    // checks
    // --------
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_trim_by_write: assert property (
        $changed(rc_trim_code) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h4))
        else $error("trim changed without write");
    a_submode_fixed: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(primarySubmode))
        else $error("submode changed");
    a_source_held: assert property (
        switch_monitor_config != 2'h0 && !$past(rst) && !$past(rst, 2) |-> $stable(sourceSelect))
        else $error("source changed while disabled");
    a_adopt_ready: assert property (
        $changed(sourceSelect) && !$past(rst) && !$past(rst, 2) |-> $past(sourceReady, 3))
        else $error("source adopted before ready");
    a_fail_off: assert property (switch_monitor_config[1] |-> !clockFail)
        else $error("fail flag while monitor off");
endmodule : osc_select_monitor

// [osc_select_pkg.sv]
// types for the oscillator select and trim block
package osc_select_pkg;
    typedef enum logic [2:0] {
        SRC_FRC = 3'h0,
        SRC_FRC_MUL = 3'h1,
        SRC_PRI = 3'h2,
        SRC_PRI_MUL = 3'h3,
        SRC_SEC = 3'h4,
        SRC_LOW_POWER_RC_OSC = 3'h5,
        SRC_FRC_DIV = 3'h7
    } source_t;
    typedef enum logic [1:0] {
        SUB_EC = 2'h0,
        SUB_XT = 2'h1,
        SUB_HS = 2'h2,
        SUB_OFF = 2'h3
    } submode_t;
    typedef enum {
        SW_IDLE,
        SW_WAIT,
        SW_ADOPT
    } switch_state_t;
endpackage : osc_select_pkg

// [test_osc_select.sv]
// testbench for the oscillator select block
`timescale 1ns/100ps
`include "osc_select_cfg.svh"
module test_osc_select;
    import osc_select_pkg::*;
    logic clk_sys, rst, cyc, stb, we, ack, ready, pulse, pulseOn, fail;
    logic [3:0] adr;
    logic [31:0] wdat, rdat;
    logic [1:0] swCfg, subCfg, subMode;
    logic [2:0] initSrc, srcSel;
    logic [5:0] trim;
    logic tk, co, co0;
    logic [2:0] mul;
    int n_errors, checks_done, cycles, n;
    source_t seq[4] = '{SRC_PRI, SRC_SEC, SRC_LOW_POWER_RC_OSC, SRC_FRC};
    logic [5:0] trimV[4] = '{`TRIM_MAX, `RST_TRIM, 6'h3F, `TRIM_MIN};
    osc_select osc_select_inst (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .switch_monitor_config(swCfg), .initial_source_config(initSrc),
        .primary_submode_config(subCfg), .sourceReady(ready), .activeClockPulse(pulse),
        .sourceSelect(srcSel), .primarySubmode(subMode), .rc_trim_code(trim),
        .usbMultiplier(mul), .cpuClockTick(tk), .clockOut(co), .clockFail(fail)
    );
    // --------
    // tasks
    // --------
    task automatic end_sim;
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, m, e);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (!w) chk(rdat & m, e);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
        bus(1'b0, a, 32'h0, m, e);
    endtask : rd
    task automatic unlock;
        wr(`OFS_KEY, 32'(`KEY_FIRST));
        wr(`OFS_KEY, 32'(`KEY_SECOND));
    endtask : unlock
    task automatic reset_dut(input logic [1:0] c, input logic [2:0] s);
        rst <= 1'b1;
        swCfg <= c;
        initSrc <= s;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : reset_dut
    // --------
    // sequence
    // --------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (pulseOn) pulse <= ~pulse;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        {rst, cyc, stb, we, ready, pulse, pulseOn} = 7'b1000001;
        {adr, wdat, subCfg} = {4'h0, 32'h0, 2'h1};
        {swCfg, initSrc} = {2'h2, 3'h2};
        {n_errors, checks_done, cycles} = '0;
        reset_dut(2'h2, 3'h2);
        ready <= 1'b1;
        chk(32'(srcSel), 32'h2);
        chk(32'(subMode), 32'h1);
        unlock();
        wr(`OFS_CONTROL, 32'h0401);
        repeat (30) @(posedge clk_sys);
        rd(`OFS_CONTROL, 32'h7001, 32'h2000);
        chk(32'(srcSel), 32'h2);
        foreach (trimV[i]) begin
            wr(`OFS_TRIM, 32'(trimV[i]));
            rd(`OFS_TRIM, 32'hFFFF, 32'(trimV[i]));
            chk(32'(trim), 32'(trimV[i]));
        end
        rd(`OFS_DIVIDE, 32'hFFFF, 32'(`RST_DIVIDE));
        wr(4'h2, 32'hFFFF);
        rd(4'h2, 32'hFFFF, 32'h0);
        chk(32'(fail), 32'h0);
        reset_dut(2'h0, 3'h0);
        chk(32'(srcSel), 32'h0);
        wr(`OFS_CONTROL, 32'h0501);
        repeat (40) @(posedge clk_sys);
        chk(32'(srcSel), 32'h0);
        foreach (seq[i]) begin
            unlock();
            wr(`OFS_CONTROL, {16'h0, 5'h0, seq[i], 8'h01});
            rd(`OFS_CONTROL, 32'h0001, 32'h1);
            for (int k = 0; k < 100 && srcSel !== seq[i]; k++) @(posedge clk_sys);
            chk(32'(srcSel), 32'(seq[i]));
            rd(`OFS_CONTROL, 32'h7001, {17'h0, seq[i], 12'h0});
        end
        wr(`OFS_DIVIDE, 32'h8523);
        rd(`OFS_DIVIDE, 32'hFFFF, 32'h8523);
        chk(32'(mul), 32'h2);
        while (tk !== 1'b1) @(posedge clk_sys);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (tk !== 1'b1);
        chk(32'(n), 32'h4);
        co0 = co;
        while (co === co0) @(posedge clk_sys);
        co0 = co;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (co === co0);
        chk(32'(n), 32'h6);
        pulseOn <= 1'b0;
        repeat (300) @(posedge clk_sys);
        chk(32'(fail), 32'h1);
        rd(`OFS_CONTROL, 32'h0008, 32'h8);
        end_sim();
    end
endmodule : test_osc_select
bind osc_select osc_select_monitor osc_select_monitor_inst (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sourceReady(sourceReady),
    .switch_monitor_config(switch_monitor_config), .sourceSelect(sourceSelect),
    .primarySubmode(primarySubmode), .rc_trim_code(rc_trim_code), .clockFail(clockFail)
);
